/* File: core/jac_bit_fifo.sv */
/*
 * jac_bit_fifo: one-bit-wide elastic store for the attenuator, depth chosen
 * at run time up to DEPTH_MAX, read data out of a register.
 * Assumes: depth_i is a power of two, flush_i pulsed whenever depth_i changes.
 */
`timescale 1ns/1ps

module jac_bit_fifo #(
	parameter int DEPTH_MAX = 32,
	parameter int AW = 5
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// control
	input wire logic flush_i,
	input wire logic [AW:0] depth_i,
	// write side
	input wire logic wr_en_i,
	input wire logic wr_bit_i,
	// read side
	input wire logic rd_req_i,
	output logic rd_bit_o,
	output logic rd_stb_o,
	// status
	output logic empty_o,
	output logic full_o
);

	logic [DEPTH_MAX-1:0] mem;
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] level;
	logic started;

	// ======================================================================
	// pointer wrap and occupancy decode
	wire logic [AW:0] depth_m1 = depth_i - {{AW{1'b0}}, 1'b1};
	wire logic [AW-1:0] ptr_mask = depth_m1[AW-1:0];
	wire logic is_full = (level >= depth_i);
	wire logic is_empty = (level == '0);
	wire logic half_full = (level >= {1'b0, depth_i[AW:1]});
	wire logic do_wr = wr_en_i & ~is_full; // overflow bits are dropped
	wire logic do_rd = rd_req_i & started & ~is_empty;
	wire logic [AW-1:0] next_wr_ptr = (wr_ptr + {{(AW-1){1'b0}}, 1'b1}) & ptr_mask;
	wire logic [AW-1:0] next_rd_ptr = (rd_ptr + {{(AW-1){1'b0}}, 1'b1}) & ptr_mask;

	assign empty_o = is_empty;
	assign full_o = is_full;

	// pointers and level; flush discards every stored bit
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || flush_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
		end else begin
			if (do_wr) wr_ptr <= next_wr_ptr;
			if (do_rd) rd_ptr <= next_rd_ptr;
			if (do_wr && !do_rd) level <= level + {{AW{1'b0}}, 1'b1};
			else if (do_rd && !do_wr) level <= level - {{AW{1'b0}}, 1'b1};
		end
	end

	// reading waits for half fill so the store sits centred; re-centre on underrun
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || flush_i) started <= 1'b0;
		else if (half_full) started <= 1'b1;
		else if (is_empty) started <= 1'b0;
	end

	// storage needs no reset, stale bits are never read
	always_ff @(posedge clk_sys_i) begin
		if (do_wr) mem[wr_ptr] <= wr_bit_i;
	end

	// registered read port
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			rd_bit_o <= 1'b0;
			rd_stb_o <= 1'b0;
		end else begin
			rd_stb_o <= do_rd;
			if (do_rd) rd_bit_o <= mem[rd_ptr];
		end
	end

endmodule : jac_bit_fifo

/* File: core/jac_ctrl_top.sv */
/*
 * jac_ctrl_top: six per-channel jitter attenuator control registers on the
 * parallel microprocessor port, with the path steering and elastic stores.
 * Assumes: pins are asynchronous to clk_sys_i and are synchronised here, except the pattern generator pins, used raw;
 * line clock pins run well below half of 250 MHz; the micro holds address
 * and data stable for the whole strobe; read ticks come from the pll logic
 * on the same clock.
 */
`timescale 1ns/1ps
`include "jac_defines.svh"

module jac_ctrl_top #(
	parameter int NCH = `JAC_NUM_CH,
	parameter int DEPTH_MAX = 32
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// parallel microprocessor port
	input wire logic up_cs_n_i,
	input wire logic up_rd_n_i,
	input wire logic up_wr_n_i,
	input wire logic [7:0] up_addr_i,
	input wire logic [7:0] up_wdata_i,
	output logic [7:0] up_rdata_o,
	output logic up_rdy_o,
	// per channel de-sync select
	input wire logic [NCH-1:0] desync_en_i,
	// transmit system side, from the mapper
	input wire logic [NCH-1:0] tx_sys_clk_i,
	input wire logic [NCH-1:0] tx_sys_data_i,
	// receive side, recovered from the line
	input wire logic [NCH-1:0] rx_rec_clk_i,
	input wire logic [NCH-1:0] rx_rec_data_i,
	// pattern generator and transmit line clock
	input wire logic [NCH-1:0] prbs_active_i,
	input wire logic [NCH-1:0] prbs_bit_i,
	input wire logic [NCH-1:0] transmit_line_clock_i,
	// smoothed read pacing from the pll
	input wire logic [NCH-1:0] atten_read_tick_i,
	// outputs towards the line and the system
	output logic [NCH-1:0] tx_line_stb_o,
	output logic [NCH-1:0] tx_line_data_o,
	output logic [NCH-1:0] rx_sys_stb_o,
	output logic [NCH-1:0] rx_sys_data_o,
	// pll and status
	output logic [NCH-1:0] fast_lock_disable_o,
	output logic [NCH-1:0] atten_active_o
);

	// ======================================================================
	// address decode, shared by read and write
	function automatic logic [3:0] ch_decode(input logic [7:0] addr);
		logic [3:0] res;
		res = 4'h0;
		case (addr)
			`JAC_CTRL_OFF_CH0: res = 4'h8;
			`JAC_CTRL_OFF_CH1: res = 4'h9;
			`JAC_CTRL_OFF_CH2: res = 4'ha;
			`JAC_CTRL_OFF_CH3: res = 4'hb;
			`JAC_CTRL_OFF_CH4: res = 4'hc;
			`JAC_CTRL_OFF_CH5: res = 4'hd;
			default: res = 4'h0;
		endcase
		return res;
	endfunction : ch_decode

	// mode bits to attenuator setting
	function automatic jac_pkg::jac_att_mode_e mode_of(input jac_pkg::jac_ctrl_s c);
		jac_pkg::jac_att_mode_e m;
		m = jac_pkg::JAC_ATT_OFF;
		if (c.atten_mode_low) m = jac_pkg::JAC_ATT_OFF;
		else if (c.atten_mode_high) m = jac_pkg::JAC_ATT_FIFO32;
		else m = jac_pkg::JAC_ATT_FIFO16;
		return m;
	endfunction : mode_of

	// ======================================================================
	// pin synchronisers, two flops each; stage 3 only feeds edge detection
	logic [2:0] bus_s1, bus_s2;
	logic [15:0] bus_d1, bus_d2;
	logic [NCH-1:0] ds_s1, ds_s2;
	logic [NCH-1:0] tc_s1, tc_s2, tc_s3, td_s1, td_s2;
	logic [NCH-1:0] rc_s1, rc_s2, rc_s3, rd_s1, rd_s2;
	logic [NCH-1:0] lc_s1, lc_s2, lc_s3;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			bus_s1 <= 3'h0;
			bus_s2 <= 3'h0;
		end else begin
			bus_s1 <= {~up_cs_n_i, ~up_rd_n_i, ~up_wr_n_i};
			bus_s2 <= bus_s1;
		end
	end

	// data and line pins carry no control meaning at reset
	always_ff @(posedge clk_sys_i) begin
		bus_d1 <= {up_addr_i, up_wdata_i};
		bus_d2 <= bus_d1;
		{ds_s1, tc_s1, td_s1, rc_s1, rd_s1, lc_s1} <= {desync_en_i, tx_sys_clk_i,
			tx_sys_data_i, rx_rec_clk_i, rx_rec_data_i, transmit_line_clock_i};
		{ds_s2, tc_s2, td_s2, rc_s2, rd_s2, lc_s2} <= {ds_s1, tc_s1, td_s1, rc_s1,
			rd_s1, lc_s1};
		{tc_s3, rc_s3, lc_s3} <= {tc_s2, rc_s2, lc_s2};
	end

	// ======================================================================
	// microprocessor sequencer: one access per strobe, held until release
	jac_pkg::jac_bus_s bus;
	jac_pkg::jac_up_state_e up_state, next_up_state;
	jac_pkg::jac_ctrl_s ctrl [NCH];
	logic [7:0] rdata;

	assign bus = '{sel: bus_s2[2], rd: bus_s2[1], wr: bus_s2[0],
		addr: bus_d2[15:8], wdata: bus_d2[7:0]};
	wire logic [3:0] hit = ch_decode(bus.addr);
	wire logic [2:0] hit_idx = hit[2:0];
	wire logic start_acc = (up_state == jac_pkg::JAC_UP_IDLE) && bus.sel && (bus.rd || bus.wr);
	wire logic do_write = start_acc && bus.wr && hit[3];
	wire logic do_read = start_acc && bus.rd;
	wire jac_pkg::jac_ctrl_s wr_val = bus.wdata[`JAC_CTRL_WIDTH-1:0];

	always_comb begin
		next_up_state = up_state;
		case (up_state)
			jac_pkg::JAC_UP_IDLE: if (start_acc) next_up_state = jac_pkg::JAC_UP_HOLD;
			jac_pkg::JAC_UP_HOLD: if (!(bus.sel && (bus.rd || bus.wr)))
				next_up_state = jac_pkg::JAC_UP_IDLE;
			default: next_up_state = jac_pkg::JAC_UP_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) up_state <= jac_pkg::JAC_UP_IDLE;
		else up_state <= next_up_state;
	end

	assign up_rdy_o = (up_state == jac_pkg::JAC_UP_HOLD);
	assign up_rdata_o = rdata;

	// read data captured once per access; reserved bits and holes read zero
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) rdata <= `JAC_RDATA_UNMAPPED;
		else if (do_read) begin
			if (hit[3]) rdata <= {3'h0, ctrl[hit_idx]};
			else rdata <= `JAC_RDATA_UNMAPPED;
		end
	end

	// ======================================================================
	// per channel registers and data paths
	for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
		jac_pkg::jac_att_mode_e mode, mode_d;
		jac_pkg::jac_stream_s tx_in, rx_in, att_in, tx_out, rx_out;
		logic ptr_rst_pulse;
		logic fifo_bit, fifo_stb;
		logic [$clog2(DEPTH_MAX):0] depth;

		wire logic wr_here = do_write && (hit_idx == 3'(ch));

		// control register; pointer reset acts on each write of one
		always_ff @(posedge clk_sys_i) begin
			if (rst_i) begin
				ctrl[ch] <= `JAC_CTRL_RESET;
				ptr_rst_pulse <= 1'b0;
				mode_d <= jac_pkg::JAC_ATT_FIFO16;
			end else begin
				if (wr_here) ctrl[ch] <= wr_val;
				ptr_rst_pulse <= wr_here && wr_val.fifo_pointer_reset;
				mode_d <= mode;
			end
		end

		assign mode = mode_of(ctrl[ch]);
		assign depth = (mode == jac_pkg::JAC_ATT_FIFO32) ? `JAC_FIFO_DEPTH_LONG
			: `JAC_FIFO_DEPTH_SHORT;

		// de-sync forces the mapper stream through the attenuator on transmit
		wire logic on_tx = ctrl[ch].atten_path_select || ds_s2[ch];
		wire logic on_rx = !on_tx;
		wire logic att_en = (mode != jac_pkg::JAC_ATT_OFF);

		assign tx_in = '{stb: tc_s2[ch] & ~tc_s3[ch], data: td_s2[ch]};
		assign rx_in = '{stb: rc_s2[ch] & ~rc_s3[ch], data: rd_s2[ch]};
		assign att_in = on_tx ? tx_in : rx_in;

		// a mode change re-centres the store rather than mixing depths
		jac_bit_fifo #(
			.DEPTH_MAX(DEPTH_MAX),
			.AW($clog2(DEPTH_MAX))
		) u_fifo (
			.clk_sys_i(clk_sys_i),
			.rst_i(rst_i),
			.flush_i(ptr_rst_pulse || (mode != mode_d) || !att_en),
			.depth_i(depth),
			.wr_en_i(att_en && att_in.stb),
			.wr_bit_i(att_in.data),
			.rd_req_i(atten_read_tick_i[ch]),
			.rd_bit_o(fifo_bit),
			.rd_stb_o(fifo_stb),
			.empty_o(),
			.full_o()
		);

		// transmit: pattern generator on line clock, else attenuated or direct
		always_comb begin
			if (prbs_active_i[ch])
				tx_out = '{stb: lc_s2[ch] & ~lc_s3[ch], data: prbs_bit_i[ch]};
			else if (att_en && on_tx)
				tx_out = '{stb: fifo_stb, data: fifo_bit};
			else
				tx_out = tx_in;
		end

		// receive: attenuated when steered here, otherwise straight through
		assign rx_out = (att_en && on_rx) ? '{stb: fifo_stb, data: fifo_bit} : rx_in;

		// registered line and system outputs
		always_ff @(posedge clk_sys_i) begin
			if (rst_i) begin
				tx_line_stb_o[ch] <= 1'b0;
				tx_line_data_o[ch] <= 1'b0;
				rx_sys_stb_o[ch] <= 1'b0;
				rx_sys_data_o[ch] <= 1'b0;
				fast_lock_disable_o[ch] <= 1'b0;
				atten_active_o[ch] <= 1'b0;
			end else begin
				tx_line_stb_o[ch] <= tx_out.stb;
				if (tx_out.stb) tx_line_data_o[ch] <= tx_out.data;
				rx_sys_stb_o[ch] <= rx_out.stb;
				if (rx_out.stb) rx_sys_data_o[ch] <= rx_out.data;
				fast_lock_disable_o[ch] <= ctrl[ch].fast_lock_disable;
				atten_active_o[ch] <= att_en;
			end
		end
	end

endmodule : jac_ctrl_top

/* File: shared/jac_defines.svh */
/*
 * jac_defines.svh: offsets, field positions, reset values and counts for the
 * per-channel jitter attenuator control block.
 * Assumes: included by bare name, after the package if both are needed.
 */
`ifndef JAC_DEFINES_SVH
`define JAC_DEFINES_SVH

// ==========================================================================
// register offsets on the microprocessor port
`define JAC_CTRL_OFF_CH0 8'h07
`define JAC_CTRL_OFF_CH1 8'h17
`define JAC_CTRL_OFF_CH2 8'h27
`define JAC_CTRL_OFF_CH3 8'h37
`define JAC_CTRL_OFF_CH4 8'h47
`define JAC_CTRL_OFF_CH5 8'h57

// ==========================================================================
// control field positions
`define JAC_BIT_MODE_LOW 0
`define JAC_BIT_PATH_SEL 1
`define JAC_BIT_MODE_HIGH 2
`define JAC_BIT_PTR_RST 3
`define JAC_BIT_FAST_LOCK_DIS 4
`define JAC_CTRL_WIDTH 5

// ==========================================================================
// reset values and sizes
`define JAC_CTRL_RESET 5'h00
`define JAC_RDATA_UNMAPPED 8'h00
`define JAC_NUM_CH 6
`define JAC_FIFO_DEPTH_SHORT 6'h10
`define JAC_FIFO_DEPTH_LONG 6'h20

`endif

/* File: shared/jac_pkg.sv */
/*
 * jac_pkg: types for the jitter attenuator control block.
 * Assumes: every user names items as jac_pkg::name, nothing is imported.
 */
package jac_pkg;

	// ======================================================================
	// attenuator setting decoded from the two mode bits
	typedef enum logic [2:0] {
		JAC_ATT_FIFO16 = 3'b001,
		JAC_ATT_FIFO32 = 3'b010,
		JAC_ATT_OFF = 3'b100
	} jac_att_mode_e;

	// microprocessor port sequencer
	typedef enum logic [1:0] {
		JAC_UP_IDLE = 2'b01,
		JAC_UP_HOLD = 2'b10
	} jac_up_state_e;

	// ======================================================================
	// one control register, msb first (bit 4 down to bit 0)
	typedef struct packed {
		logic fast_lock_disable;
		logic fifo_pointer_reset;
		logic atten_mode_high;
		logic atten_path_select;
		logic atten_mode_low;
	} jac_ctrl_s;

	// synchronised microprocessor request, strobes active high here
	typedef struct packed {
		logic sel;
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} jac_bus_s;

	// one serial bit stream: strobe marks a clock edge of the line
	typedef struct packed {
		logic stb;
		logic data;
	} jac_stream_s;

endpackage : jac_pkg

/* File: tb/jac_ctrl_properties.sv */
/* jac_ctrl_properties: port assertions for jac_ctrl_top, bound below.
   Assumes: one clock; channel 0 is shadowed from acknowledged writes. */
`timescale 1ns/1ps

module jac_ctrl_properties #(
	parameter int NCH = 6
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// microprocessor port
	input wire logic up_cs_n_i,
	input wire logic up_rd_n_i,
	input wire logic up_wr_n_i,
	input wire logic [7:0] up_addr_i,
	input wire logic [7:0] up_wdata_i,
	input wire logic [7:0] up_rdata_o,
	input wire logic up_rdy_o,
	// channel pins
	input wire logic [NCH-1:0] desync_en_i,
	input wire logic [NCH-1:0] prbs_active_i,
	input wire logic [NCH-1:0] atten_read_tick_i,
	input wire logic [NCH-1:0] tx_line_stb_o,
	input wire logic [NCH-1:0] rx_sys_stb_o,
	input wire logic [NCH-1:0] fast_lock_disable_o,
	input wire logic [NCH-1:0] atten_active_o
);
	default clocking dc @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	// ======================================================================
	// helper: shadow of channel 0 and a settle counter
	logic rdy_q;
	logic [1:0] pin_q;
	logic [7:0] sh;
	logic [4:0] quiet;
	wire wr0 = up_rdy_o && !rdy_q && !up_wr_n_i && up_addr_i == 8'h07;
	wire [1:0] pins = {desync_en_i[0], prbs_active_i[0]};
	wire calm = quiet > 5'h0c; // pipelines drained after any change
	wire rd_ack = up_rdy_o && !up_rd_n_i;
	wire unmapped = up_addr_i[3:0] != 4'h7 || up_addr_i[7:4] > 4'h5;

	// counter restarts on every channel 0 write or mode pin change
	always_ff @(posedge clk_sys_i) begin
		rdy_q <= up_rdy_o;
		pin_q <= pins;
		sh <= rst_i ? 8'h00 : (wr0 ? up_wdata_i : sh);
		if (rst_i || wr0 || pins != pin_q)
			quiet <= 5'h00;
		else if (quiet != 5'h1f)
			quiet <= quiet + 5'h01;
	end

	// ======================================================================
	// assertions
	chk_rdy_after_cs: assert property ($fell(up_cs_n_i) |-> ##[1:6] up_rdy_o)
		else $error("no ready after chip select");
	chk_reserved_zero: assert property (rd_ack |-> up_rdata_o[7:5] == 3'b000)
		else $error("reserved bits read nonzero");
	chk_unmapped_zero: assert property (rd_ack && unmapped |-> up_rdata_o == 8'h00)
		else $error("unmapped read nonzero");
	chk_mode_active: assert property (calm |-> atten_active_o[0] == !sh[0])
		else $error("attenuator activity disagrees with mode");
	chk_fast_lock: assert property (calm |-> fast_lock_disable_o[0] == sh[4])
		else $error("fast lock output disagrees with control");
	chk_rx_paced: assert property (calm && sh[1:0] == 2'b00 && !desync_en_i[0]
		&& rx_sys_stb_o[0] |-> $past(atten_read_tick_i[0], 2))
		else $error("receive bit not paced by read tick");
	chk_tx_paced: assert property (calm && !sh[0] && (sh[1] || desync_en_i[0])
		&& !prbs_active_i[0] && tx_line_stb_o[0] |-> $past(atten_read_tick_i[0], 2))
		else $error("transmit bit not paced by read tick");
	chk_flush_empty: assert property (wr0 && calm && sh[1:0] == 2'b00 && up_wdata_i[3]
		&& up_wdata_i[1:0] == 2'b00 && !desync_en_i[0] |-> ##3 (!rx_sys_stb_o[0]) [*8])
		else $error("bit delivered right after flush");
endmodule : jac_ctrl_properties

bind jac_ctrl_top jac_ctrl_properties #(.NCH(NCH)) u_chk (.clk_sys_i, .rst_i, .up_cs_n_i,
	.up_rd_n_i, .up_wr_n_i, .up_addr_i, .up_wdata_i, .up_rdata_o, .up_rdy_o, .desync_en_i,
	.prbs_active_i, .atten_read_tick_i, .tx_line_stb_o, .rx_sys_stb_o, .fast_lock_disable_o,
	.atten_active_o);

/* File: tb/jac_map_model.sv */
/* jac_map_model: mapper stand-in sending one de-mapped bit stream.
   Assumes: design and bench sample it on clk_sys_i. */
`timescale 1ns/1ps

module jac_map_model (
	// clock
	input wire logic clk_sys_i,
	// control
	input wire logic run_i,
	input wire logic slow_i,
	// stream
	output logic clk_o = 1'b0,
	output logic data_o = 1'b0
);
	logic [6:0] lfsr = 7'h5b;
	logic live = 1'b0;
	int cnt = 0;

	// ======================================================================
	// half period 2 or 6 cycles; while running, data moves only as a burst starts or the clock falls
	always @(posedge clk_sys_i) begin
		live <= run_i;
		cnt <= cnt + 1;
		if (!run_i) begin
			clk_o <= 1'b0; // clock stands still between bursts
			data_o <= ~data_o; // idle line shows no stale bit
		end else if (!live || cnt >= (slow_i ? 5 : 1)) begin
			cnt <= 0;
			clk_o <= live && !clk_o;
			if (!live || clk_o) begin
				data_o <= lfsr[6];
				lfsr <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
			end
		end
	end
endmodule : jac_map_model

/* File: tb/test_jitter_attenuator_control.sv */
/* test_jitter_attenuator_control: self-checking bench for jac_ctrl_top.
   Assumes: mapper model feeds every transmit system input. */
`timescale 1ns/1ps

module test_jitter_attenuator_control;
	// ======================================================================
	// pins and bench state
	logic clk_sys_i = 1'b0, rst_i = 1'b1, up_cs_n_i = 1'b1, up_rd_n_i = 1'b1, up_wr_n_i = 1'b1;
	logic [7:0] up_addr_i = 8'h00, up_wdata_i = 8'h00, up_rdata_o, r, d, e;
	logic [5:0] desync_en_i = 6'h00, rx_rec_clk_i = 6'h00, rx_rec_data_i = 6'h00;
	logic [5:0] prbs_active_i = 6'h00, prbs_bit_i = 6'h00, transmit_line_clock_i = 6'h00;
	logic [5:0] atten_read_tick_i = 6'h00, tx_line_stb_o, tx_line_data_o, rx_sys_stb_o;
	logic [5:0] rx_sys_data_o, fast_lock_disable_o, atten_active_o;
	logic up_rdy_o, mclk, mdat, run = 1'b0, slow = 1'b0, tick_on = 1'b0, clk_q = 1'b0;
	logic rxc_q = 1'b0;
	logic [1:0] mon = 2'h0;
	logic [7:0] shadow [6] = '{default: 8'h00};
	logic q[$], qr[$];
	int n_fail = 0, n_compared = 0, n_out = 0, n_rx = 0, tmr = 0;
	wire [5:0] tx_sys_clk_i = {6{mclk}};
	wire [5:0] tx_sys_data_i = {6{mdat}};

	jac_ctrl_top #(.NCH(6)) u_dut (.clk_sys_i, .rst_i, .up_cs_n_i, .up_rd_n_i, .up_wr_n_i,
		.up_addr_i, .up_wdata_i, .up_rdata_o, .up_rdy_o, .desync_en_i, .tx_sys_clk_i,
		.tx_sys_data_i, .rx_rec_clk_i, .rx_rec_data_i, .prbs_active_i, .prbs_bit_i,
		.transmit_line_clock_i, .atten_read_tick_i, .tx_line_stb_o, .tx_line_data_o,
		.rx_sys_stb_o, .rx_sys_data_o, .fast_lock_disable_o, .atten_active_o);
	jac_map_model u_map (.clk_sys_i, .run_i(run), .slow_i(slow), .clk_o(mclk), .data_o(mdat));

	initial forever #2 clk_sys_i = ~clk_sys_i;

	// ======================================================================
	// checking and closing
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic give_verdict();
		if (n_fail == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	// one column of the shadow registers, one bit per channel
	function automatic logic [7:0] col(input int b, input logic inv);
		col = 8'h00;
		for (int i = 0; i < 6; i++) col[i] = shadow[i][b] ^ inv;
	endfunction : col

	// one port access; read data lands in r
	task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] dat);
		int i;
		i = 0;
		up_cs_n_i <= 1'b0;
		up_rd_n_i <= wr;
		up_wr_n_i <= !wr;
		up_addr_i <= a;
		up_wdata_i <= dat;
		do begin
			@(posedge clk_sys_i);
			i++;
		end while (up_rdy_o !== 1'b1 && i < 20);
		r = up_rdata_o;
		up_cs_n_i <= 1'b1;
		up_rd_n_i <= 1'b1;
		up_wr_n_i <= 1'b1;
		if (up_rdy_o !== 1'b1) begin
			n_fail++;
			give_verdict();
		end
		repeat (5) @(posedge clk_sys_i);
	endtask : acc

	// one stream phase: configure channel 0, then let traffic run
	task automatic phase(input logic [7:0] cfg, input logic ds, input logic sl, input logic tk);
		run <= 1'b0;
		tick_on <= 1'b0;
		mon <= 2'h0;
		repeat (16) @(posedge clk_sys_i);
		acc(1'b1, 8'h07, cfg);
		desync_en_i <= {6{ds}};
		repeat (16) @(posedge clk_sys_i);
		q.delete();
		qr.delete();
		n_out = 0;
		n_rx = 0;
		mon <= 2'h1;
		run <= 1'b1;
		slow <= sl;
		tick_on <= tk;
		repeat (500) @(posedge clk_sys_i);
		check("bits out", {7'h00, n_out > 8}, 8'h01);
	endtask : phase

	// ======================================================================
	// line-side pacing and output monitor
	always @(posedge clk_sys_i) begin
		tmr <= tmr + 1;
		rx_rec_clk_i <= {6{run && tmr[1]}}; // still between phases, no stray bits
		if (tmr[1:0] == 2'b11) rx_rec_data_i <= 6'($urandom);
		transmit_line_clock_i <= {6{tmr[2]}};
		atten_read_tick_i <= {6{tick_on && tmr % 3 == 0}};
		clk_q <= mclk;
		rxc_q <= rx_rec_clk_i[0];
		if (mclk && !clk_q) q.push_back(mdat);
		if (rx_rec_clk_i[0] && !rxc_q) qr.push_back(rx_rec_data_i[0]);
		if (rx_sys_stb_o[0]) n_rx++;
		if (tx_line_stb_o[0] && mon != 2'h0) n_out++;
		if (tx_line_stb_o[0] && mon == 2'h1) begin
			e = q.size() > 0 ? {7'h00, q.pop_front()} : 8'hff;
			check("line bit", {7'h00, tx_line_data_o[0]}, e);
		end
		if (tx_line_stb_o[0] && mon == 2'h2)
			check("pattern bit", {7'h00, tx_line_data_o[0]}, {7'h00, prbs_bit_i[0]});
		if (rx_sys_stb_o[0] && mon == 2'h1) begin
			e = qr.size() > 0 ? {7'h00, qr.pop_front()} : 8'hff;
			check("rx bit", {7'h00, rx_sys_data_o[0]}, e);
		end
	end

	// ======================================================================
	// main sequence
	initial begin
		int k;
		int c;
		void'($urandom(24769));
		repeat (8) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		for (k = 0; k < 6; k++) begin
			acc(1'b0, {k[3:0], 4'h7}, 8'h00);
			check("reset value", r, 8'h00);
		end
		check("active", {2'h0, atten_active_o}, col(0, 1'b1));
		// random writes, every mode code first, unmapped 0x67 in the mix
		for (k = 0; k < 28; k++) begin
			c = k % 7;
			d = 8'($urandom);
			if (k < 4) d[2:0] = {k[1], d[1], k[0]};
			acc(1'b1, {c[3:0], 4'h7}, d);
			acc(1'b0, {c[3:0], 4'h7}, 8'h00);
			if (c < 6) shadow[c] = d;
			check("read back", r, c < 6 ? {3'h0, d[4:0]} : 8'h00);
			check("active", {2'h0, atten_active_o}, col(0, 1'b1));
			check("fast lock", {2'h0, fast_lock_disable_o}, col(4, 1'b0));
		end
		phase(8'h08, 1'b0, 1'b0, 1'b1);
		check("rx strobes", {7'h00, n_rx > 0}, 8'h01);
		acc(1'b1, 8'h07, 8'h08);
		n_rx = 0;
		repeat (16) @(posedge clk_sys_i);
		check("after flush", {7'h00, n_rx > 0}, 8'h00);
		phase(8'h0a, 1'b0, 1'b0, 1'b1);
		phase(8'h0e, 1'b0, 1'b1, 1'b1);
		phase(8'h08, 1'b1, 1'b0, 1'b1);
		phase(8'h0d, 1'b0, 1'b1, 1'b0);
		run <= 1'b0;
		prbs_active_i <= 6'h3f;
		for (k = 0; k < 2; k++) begin
			mon <= 2'h0;
			prbs_bit_i <= {6{k[0]}};
			repeat (16) @(posedge clk_sys_i);
			n_out = 0;
			mon <= 2'h2;
			repeat (200) @(posedge clk_sys_i);
			check("pattern strobes", {7'h00, n_out > 4}, 8'h01);
		end
		give_verdict();
	end
endmodule : test_jitter_attenuator_control
